// ### logic/plt_limit_trip.sv
// Upper-limit protection and operation condition status for two pressure transducers.
// Assumes the host's text is parsed elsewhere into one decoded command per cycle,
// and that measurements arrive in pascal as a one-cycle strobe per transducer.
`timescale 1ns/1ns
module plt_limit_trip (
  // Clock, reset and clock enable.
  input  wire logic                                         core_clk,
  input  wire logic                                         sys_rst,
  input  wire logic                                         ce,
  // Decoded command from the host.
  input  wire logic                                         cmd_valid,
  input  wire plt_pkg::plt_cmd_type                         cmd,
  input  wire logic [2:0]                                   default_unit,
  // Transducer setup and measurements.
  input  wire plt_pkg::plt_xdcr_cfg_type [plt_pkg::XDCR_COUNT-1:0] xdcr_cfg,
  input  wire logic [plt_pkg::XDCR_COUNT-1:0]               meas_valid,
  input  wire logic [plt_pkg::XDCR_COUNT-1:0][31:0]         meas_pressure,
  // Instrument event register bits and their summary enables.
  input  wire logic [1:0]                                   inst_event,
  input  wire logic [1:0]                                   inst_enable,
  // Reply to the host.
  output logic                                              rsp_valid,
  output logic                                              rsp_error,
  output logic [31:0]                                       rsp_data,
  // Status seen by the rest of the instrument.
  output logic [plt_pkg::COND_WIDTH-1:0]                    operation_condition,
  output logic [plt_pkg::XDCR_COUNT-1:0]                    limit_tripped
);

  plt_pkg::plt_state_type st;
  plt_pkg::plt_state_type next_st;

  logic [31:0]                       conv_pascal;
  logic                              conv_bad;
  logic                              xi;
  logic                              suffix_ok;
  logic [32:0]                       cap;
  logic [31:0]                       sel_limit [plt_pkg::XDCR_COUNT];
  logic [plt_pkg::XDCR_COUNT-1:0]    trip_hit;
  logic                              summary;

  // The unit is resolved before the range check so that the check is in pascal.
  plt_unit_conv u_conv (
    .value        (cmd.value),
    .unit_given   (cmd.unit_given),
    .unit         (cmd.unit),
    .default_unit (default_unit),
    .pascal       (conv_pascal),
    .bad          (conv_bad)
  );

  // Suffix decode; a missing suffix means the high-range transducer.
  assign xi        = (cmd.suffix == plt_pkg::SUFFIX_LOW);
  assign suffix_ok = (cmd.suffix <= plt_pkg::SUFFIX_LOW);
  // Largest limit allowed on the active range, kept 33 bits wide so the margin never wraps.
  assign cap = {1'b0, xdcr_cfg[xi].span} + {1'b0, (xdcr_cfg[xi].span >> plt_pkg::MARGIN_SHIFT)};
  // Only enabled instrument events feed the summary.
  assign summary = |(inst_event & inst_enable);

  // Per transducer limit selection and comparison.
  for (genvar g = 0; g < plt_pkg::XDCR_COUNT; g++) begin : g_xdcr
    logic rng_ok;
    logic use_abs;
    assign rng_ok  = (xdcr_cfg[g].range <= plt_pkg::RANGE_LAST);
    // A gauge-only transducer always compares against its gauge limit.
    assign use_abs = xdcr_cfg[g].mode_abs && !xdcr_cfg[g].gauge_only;
    assign sel_limit[g] = rng_ok ? st.limit[g][xdcr_cfg[g].range][use_abs] : plt_pkg::LIMIT_RESET;
    assign trip_hit[g]  = meas_valid[g] && rng_ok && (meas_pressure[g] > sel_limit[g]);
  end

  // Next state: command handling first, trips last so a trip in a clear cycle survives.
  always_comb begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    next_st.op_cond   = '0;
    next_st.op_cond[plt_pkg::COND_SUMMARY_BIT] = summary;
    if (cmd_valid) begin
      next_st.rsp_valid = 1'b1;
      next_st.rsp_error = 1'b0;
      next_st.rsp_data  = '0;
      if (!suffix_ok && cmd.op != plt_pkg::OP_COND_QRY) begin
        next_st.rsp_error = 1'b1;
      end else begin
        case (cmd.op)
          plt_pkg::OP_GAUGE_SET, plt_pkg::OP_ABS_SET: begin
            // Value is in the named unit, else the default one; the abs limit is stored even if gauge-only.
            if (conv_bad || xdcr_cfg[xi].range > plt_pkg::RANGE_LAST || {1'b0, conv_pascal} > cap) begin
              next_st.rsp_error = 1'b1;
            end else begin
              next_st.limit[xi][xdcr_cfg[xi].range][cmd.op == plt_pkg::OP_ABS_SET] = conv_pascal;
            end
          end
          plt_pkg::OP_GAUGE_QRY, plt_pkg::OP_ABS_QRY: begin
            if (xdcr_cfg[xi].range > plt_pkg::RANGE_LAST) begin
              next_st.rsp_error = 1'b1;
            end else begin
              next_st.rsp_data = st.limit[xi][xdcr_cfg[xi].range][cmd.op == plt_pkg::OP_ABS_QRY];
            end
          end
          plt_pkg::OP_TRIP_QRY: begin
            next_st.rsp_data = {31'h0000_0000, st.tripped[xi]};
          end
          plt_pkg::OP_TRIP_CLR: begin
            next_st.tripped[xi] = 1'b0;
          end
          plt_pkg::OP_COND_QRY: begin
            next_st.rsp_data = {16'h0000, st.op_cond};
          end
          default: begin
            next_st.rsp_error = 1'b1;
          end
        endcase
      end
    end
    // Set wins over a clear arriving in the same cycle.
    for (int i = 0; i < plt_pkg::XDCR_COUNT; i++) begin
      if (trip_hit[i]) begin
        next_st.tripped[i] = 1'b1;
      end
    end
  end

  // State register; a low clock enable freezes everything.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st           <= '0;
      st.limit     <= {(plt_pkg::XDCR_COUNT * plt_pkg::RANGE_COUNT * plt_pkg::MODE_COUNT){plt_pkg::LIMIT_RESET}};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rsp_valid           = st.rsp_valid;
  assign rsp_error           = st.rsp_error;
  assign rsp_data            = st.rsp_data;
  assign operation_condition = st.op_cond;
  assign limit_tripped       = st.tripped;

  // Checks on the block's own outputs and internal state.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic clr0;
  assign clr0 = cmd_valid && cmd.op == plt_pkg::OP_TRIP_CLR && suffix_ok && !xi;

  property p_trip_set;
    ce && trip_hit[0] |=> limit_tripped[0];
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip not flagged after exceed");

  property p_trip_sticky;
    ce && limit_tripped[0] && !clr0 |=> limit_tripped[0];
  endproperty
  a_trip_sticky: assert property (p_trip_sticky) else $error("trip flag dropped without clear");

  property p_trip_clear;
    ce && clr0 && !trip_hit[0] |=> !limit_tripped[0];
  endproperty
  a_trip_clear: assert property (p_trip_clear) else $error("trip flag not cleared");

  property p_trip_query;
    ce && cmd_valid && cmd.op == plt_pkg::OP_TRIP_QRY && suffix_ok && !xi
      |=> rsp_valid && rsp_data == {31'h0000_0000, $past(limit_tripped[0])};
  endproperty
  a_trip_query: assert property (p_trip_query) else $error("trip query answer wrong");

  property p_cond_value;
    ce |=> operation_condition == {2'h0, $past(summary), 13'h0000};
  endproperty
  a_cond_value: assert property (p_cond_value) else $error("condition register value wrong");

  property p_cond_query;
    ce && cmd_valid && cmd.op == plt_pkg::OP_COND_QRY |=> rsp_data == {16'h0000, $past(operation_condition)};
  endproperty
  a_cond_query: assert property (p_cond_query) else $error("condition query answer wrong");

  property p_over_span;
    ce && cmd_valid && suffix_ok && cmd.op == plt_pkg::OP_GAUGE_SET && {1'b0, conv_pascal} > cap
      |=> rsp_valid && rsp_error;
  endproperty
  a_over_span: assert property (p_over_span) else $error("limit above span accepted");

  property p_gauge_only;
    xdcr_cfg[0].gauge_only && xdcr_cfg[0].range <= plt_pkg::RANGE_LAST
      |-> sel_limit[0] == st.limit[0][xdcr_cfg[0].range][plt_pkg::MODE_GAUGE];
  endproperty
  a_gauge_only: assert property (p_gauge_only) else $error("gauge-only compared to abs limit");

  property p_freeze;
    !ce |=> $stable(st);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  // A clear of the low-range flag must not hide a trip that lands in the same cycle.
  property p_set_wins;
    ce && cmd_valid && cmd.op == plt_pkg::OP_TRIP_CLR && suffix_ok && xi && trip_hit[1]
      |=> limit_tripped[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a trip in the same cycle");

  // A limit in an unknown unit, or one that overflows, must leave every stored limit alone.
  property p_refused_keeps;
    ce && cmd_valid && (cmd.op == plt_pkg::OP_GAUGE_SET || cmd.op == plt_pkg::OP_ABS_SET) && conv_bad
      |=> $stable(st.limit);
  endproperty
  a_refused_keeps: assert property (p_refused_keeps) else $error("refused limit was stored");

  c_trip: cover property (ce && trip_hit[0] ##1 limit_tripped[0]);
  c_clear: cover property (limit_tripped[0] ##1 ce && clr0 ##1 !limit_tripped[0]);
  c_cond: cover property (ce && cmd_valid && cmd.op == plt_pkg::OP_COND_QRY && summary);
  c_freeze: cover property (!ce && meas_valid[1]);

endmodule

// ### logic/plt_pkg.sv
// Package for the pressure upper-limit trip and operation condition block.
// Assumes one 25 MHz clock; pressures travel as unsigned integers in pascal.
package plt_pkg;

  // Transducers, ranges and measurement modes.
  localparam int unsigned XDCR_COUNT  = 2;
  localparam int unsigned RANGE_COUNT = 3;
  localparam int unsigned MODE_COUNT  = 2;
  localparam logic [1:0]  SUFFIX_NONE = 2'h0;
  localparam logic [1:0]  SUFFIX_LOW  = 2'h2;
  localparam logic [1:0]  RANGE_LAST  = 2'h2;
  localparam logic        MODE_GAUGE  = 1'h0;
  localparam logic        MODE_ABS    = 1'h1;

  // A limit may sit this far above span: span plus span shifted right by this amount.
  localparam int unsigned MARGIN_SHIFT = 4;

  // Limits start at full scale so that nothing trips before software sets one.
  localparam logic [31:0] LIMIT_RESET = 32'hffff_ffff;

  // Operation condition register layout.
  localparam int unsigned COND_WIDTH       = 16;
  localparam int unsigned COND_SUMMARY_BIT = 13;

  // Pressure units and their factors to pascal.
  typedef enum logic [2:0] {
    UNIT_PA   = 3'h0,
    UNIT_KPA  = 3'h1,
    UNIT_MPA  = 3'h2,
    UNIT_PSI  = 3'h3,
    UNIT_BAR  = 3'h4,
    UNIT_MBAR = 3'h5
  } plt_unit_type;
  localparam logic [31:0] FACTOR_PA   = 32'h0000_0001;
  localparam logic [31:0] FACTOR_KPA  = 32'h0000_03e8;
  localparam logic [31:0] FACTOR_MPA  = 32'h000f_4240;
  localparam logic [31:0] FACTOR_PSI  = 32'h0000_1aef;
  localparam logic [31:0] FACTOR_BAR  = 32'h0001_86a0;
  localparam logic [31:0] FACTOR_MBAR = 32'h0000_0064;

  // Decoded host commands.
  typedef enum logic [2:0] {
    OP_GAUGE_SET = 3'h0,
    OP_ABS_SET   = 3'h1,
    OP_GAUGE_QRY = 3'h2,
    OP_ABS_QRY   = 3'h3,
    OP_TRIP_QRY  = 3'h4,
    OP_TRIP_CLR  = 3'h5,
    OP_COND_QRY  = 3'h6
  } plt_op_type;

  // One decoded command from the host's text parser.
  typedef struct packed {
    plt_op_type  op;
    logic [1:0]  suffix;
    logic        unit_given;
    logic [2:0]  unit;
    logic [31:0] value;
  } plt_cmd_type;

  // Present setup of one transducer.
  typedef struct packed {
    logic [1:0]  range;
    logic        mode_abs;
    logic        gauge_only;
    logic [31:0] span;
  } plt_xdcr_cfg_type;

  // Whole state of the main module.
  typedef struct packed {
    logic [XDCR_COUNT-1:0][RANGE_COUNT-1:0][MODE_COUNT-1:0][31:0] limit;
    logic [XDCR_COUNT-1:0]                                        tripped;
    logic                                                         rsp_valid;
    logic                                                         rsp_error;
    logic [31:0]                                                  rsp_data;
    logic [COND_WIDTH-1:0]                                        op_cond;
  } plt_state_type;

endpackage

// ### logic/plt_unit_conv.sv
// Converts a limit value from its stated or default unit into pascal.
// Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ns
module plt_unit_conv (
  // Value as given by the host.
  input  wire logic [31:0] value,
  input  wire logic        unit_given,
  input  wire logic [2:0]  unit,
  // Unit in force when the host names none.
  input  wire logic [2:0]  default_unit,
  // Result in pascal, and a flag for an unknown unit or overflow.
  output logic      [31:0] pascal,
  output logic             bad
);

  logic [2:0]  eff_unit;
  logic [31:0] factor;
  logic [63:0] product;

  // Pick the unit, then scale; an overflowing product is refused rather than wrapped.
  always_comb begin
    eff_unit = unit_given ? unit : default_unit;
    bad      = 1'b0;
    case (eff_unit)
      plt_pkg::UNIT_PA:   factor = plt_pkg::FACTOR_PA;
      plt_pkg::UNIT_KPA:  factor = plt_pkg::FACTOR_KPA;
      plt_pkg::UNIT_MPA:  factor = plt_pkg::FACTOR_MPA;
      plt_pkg::UNIT_PSI:  factor = plt_pkg::FACTOR_PSI;
      plt_pkg::UNIT_BAR:  factor = plt_pkg::FACTOR_BAR;
      plt_pkg::UNIT_MBAR: factor = plt_pkg::FACTOR_MBAR;
      default: begin
        factor = '0;
        bad    = 1'b1;
      end
    endcase
    product = {32'h0000_0000, value} * {32'h0000_0000, factor};
    pascal  = product[31:0];
    if (product[63:32] != '0) begin
      bad = 1'b1;
    end
  end

endmodule

// ### tb/plt_host_model.sv
// Host model that issues decoded limit and status commands and collects each reply.
// Assumes the reply is registered on the edge that takes the command and read just after that edge.
`timescale 1ns/1ns
module plt_host_model (
  // Clock.
  input  wire logic                 core_clk,
  // Command towards the block.
  output plt_pkg::plt_cmd_type      cmd,
  output logic                      cmd_valid,
  // Reply from the block.
  input  wire logic                 rsp_valid,
  input  wire logic                 rsp_error,
  input  wire logic [31:0]          rsp_data
);
  // Idle command value is all zero until the first request.
  initial begin
    cmd_valid = 1'h0;
    cmd       = '0;
  end

  // One command, one reply; the value is inverted afterwards so that a stale value is never read as fresh.
  task automatic issue(input plt_pkg::plt_op_type op, input logic [1:0] sfx, input logic ug, input logic [2:0] u,
                       input logic [31:0] v, output logic ok, output logic err, output logic [31:0] d);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'h1;
    cmd       = '{op, sfx, ug, u, v};
    @(posedge core_clk);
    #1;
    ok        = rsp_valid;
    err       = rsp_error;
    d         = rsp_data;
    cmd_valid = 1'h0;
    cmd.value = ~v;
  endtask
endmodule

// ### tb/plt_limit_trip_test.sv
// Self-checking bench for the upper-limit trip and operation condition block.
// Assumes the host model in its own file; ce is lowered once to show that it freezes the block.
`timescale 1ns/1ns
module plt_limit_trip_test;
  logic                             core_clk;
  logic                             sys_rst;
  logic                             ce;
  logic                             cmd_valid;
  plt_pkg::plt_cmd_type             cmd;
  logic [2:0]                       default_unit;
  plt_pkg::plt_xdcr_cfg_type [1:0]  xdcr_cfg;
  logic [1:0]                       meas_valid;
  logic [1:0][31:0]                 meas_pressure;
  logic [1:0]                       inst_event;
  logic [1:0]                       inst_enable;
  logic                             rsp_valid;
  logic                             rsp_error;
  logic [31:0]                      rsp_data;
  logic [15:0]                      operation_condition;
  logic [1:0]                       limit_tripped;
  int                               n_mismatch;
  int                               num_checks;
  int                               cycles;

  plt_limit_trip dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
    .default_unit(default_unit), .xdcr_cfg(xdcr_cfg), .meas_valid(meas_valid), .meas_pressure(meas_pressure),
    .inst_event(inst_event), .inst_enable(inst_enable), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_data(rsp_data), .operation_condition(operation_condition), .limit_tripped(limit_tripped));
  plt_host_model host (.core_clk(core_clk), .cmd(cmd), .cmd_valid(cmd_valid), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_data(rsp_data));

  // Clock at 25 MHz.
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  // Hang guard; the tests need under two hundred cycles.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Issues a command and checks the reply; data is only checked on an accepted command.
  task automatic cmdx(input plt_pkg::plt_op_type op, input logic [1:0] sfx, input logic ug, input logic [2:0] u,
                      input logic [31:0] v, input logic exp_err, input logic [31:0] exp_d);
    logic        ok;
    logic        err;
    logic [31:0] d;
    host.issue(op, sfx, ug, u, v, ok, err, d);
    chk("rsp_valid", 32'h1, {31'h0, ok});
    chk("rsp_error", {31'h0, exp_err}, {31'h0, err});
    if (!exp_err) chk("rsp_data", exp_d, d);
  endtask

  // One measurement strobe, then the sticky flags are compared.
  task automatic meas(input int i, input logic [31:0] p, input logic [1:0] exp_trip);
    @(posedge core_clk);
    #1;
    meas_valid[i]    = 1'h1;
    meas_pressure[i] = p;
    @(posedge core_clk);
    #1;
    meas_valid[i]    = 1'h0;
    meas_pressure[i] = ~p;
    chk("limit_tripped", {30'h0, exp_trip}, {30'h0, limit_tripped});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    ce = 1'h1;
    sys_rst = 1'h1;
    default_unit = plt_pkg::UNIT_PA;
    xdcr_cfg[0] = '{2'h0, 1'h0, 1'h0, 32'h0000_3e80};
    xdcr_cfg[1] = '{2'h0, 1'h0, 1'h0, 32'h0000_03e8};
    meas_valid = 2'h0;
    meas_pressure = '0;
    inst_event = 2'h0;
    inst_enable = 2'h0;
    repeat (20) @(posedge core_clk);
    #1;
    sys_rst = 1'h0;
    chk("reset_cond", 32'h0, {16'h0, operation_condition});
    chk("reset_trip", 32'h0, {30'h0, limit_tripped});
    cmdx(plt_pkg::OP_GAUGE_SET, 2'h1, 1'h1, plt_pkg::UNIT_KPA, 32'h0000_000a, 1'h0, 32'h0);
    cmdx(plt_pkg::OP_ABS_SET, 2'h0, 1'h1, plt_pkg::UNIT_PA, 32'h0000_3a98, 1'h0, 32'h0);
    cmdx(plt_pkg::OP_GAUGE_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0000_2710);
    cmdx(plt_pkg::OP_ABS_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0000_3a98);
    default_unit = plt_pkg::UNIT_KPA;
    cmdx(plt_pkg::OP_GAUGE_SET, 2'h1, 1'h0, plt_pkg::UNIT_PA, 32'h0000_000c, 1'h0, 32'h0);
    cmdx(plt_pkg::OP_GAUGE_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0000_2ee0);
    cmdx(plt_pkg::OP_GAUGE_SET, 2'h1, 1'h1, plt_pkg::UNIT_PA, 32'h0000_4268, 1'h0, 32'h0);
    cmdx(plt_pkg::OP_GAUGE_SET, 2'h1, 1'h1, plt_pkg::UNIT_PA, 32'h0000_4269, 1'h1, 32'h0);
    cmdx(plt_pkg::OP_GAUGE_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0000_4268);
    $display("test limits done");
    meas(0, 32'h0000_4268, 2'h0);
    meas(0, 32'h0000_4269, 2'h1);
    cmdx(plt_pkg::OP_TRIP_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h1);
    cmdx(plt_pkg::OP_TRIP_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h1);
    cmdx(plt_pkg::OP_TRIP_QRY, 2'h2, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0);
    cmdx(plt_pkg::OP_GAUGE_SET, 2'h2, 1'h1, plt_pkg::UNIT_PA, 32'h0000_03e8, 1'h0, 32'h0);
    meas(1, 32'h0000_03e9, 2'h3);
    cmdx(plt_pkg::OP_TRIP_CLR, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0);
    chk("clear_high", 32'h2, {30'h0, limit_tripped});
    cmdx(plt_pkg::OP_TRIP_CLR, 2'h2, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0);
    chk("clear_low", 32'h0, {30'h0, limit_tripped});
    $display("test trip done");
    xdcr_cfg[0].mode_abs = 1'h1;
    xdcr_cfg[0].gauge_only = 1'h1;
    cmdx(plt_pkg::OP_ABS_SET, 2'h1, 1'h1, plt_pkg::UNIT_PA, 32'h0000_01f4, 1'h0, 32'h0);
    meas(0, 32'h0000_0258, 2'h0);
    meas(0, 32'h0000_4269, 2'h1);
    xdcr_cfg[0].range = 2'h1;
    cmdx(plt_pkg::OP_GAUGE_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'hffff_ffff);
    cmdx(plt_pkg::OP_GAUGE_QRY, 2'h3, 1'h0, 3'h0, 32'h0, 1'h1, 32'h0);
    $display("test gauge only done");
    // The psi, bar, MPa, mbar and kPa units and one unknown code on a wide span; refused values must leave the stored limit as it was.
    xdcr_cfg[0].span = 32'h000f_4240;
    cmdx(plt_pkg::OP_GAUGE_SET, 2'h1, 1'h1, plt_pkg::UNIT_PSI, 32'h0000_0002, 1'h0, 32'h0);
    cmdx(plt_pkg::OP_GAUGE_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0000_35de);
    cmdx(plt_pkg::OP_GAUGE_SET, 2'h1, 1'h1, plt_pkg::UNIT_BAR, 32'h0000_0005, 1'h0, 32'h0);
    cmdx(plt_pkg::OP_GAUGE_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0007_a120);
    cmdx(plt_pkg::OP_ABS_SET, 2'h1, 1'h1, plt_pkg::UNIT_MPA, 32'h0000_0001, 1'h0, 32'h0);
    cmdx(plt_pkg::OP_ABS_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h000f_4240);
    cmdx(plt_pkg::OP_ABS_SET, 2'h1, 1'h1, plt_pkg::UNIT_MBAR, 32'h0000_0096, 1'h0, 32'h0);
    cmdx(plt_pkg::OP_ABS_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0000_3a98);
    cmdx(plt_pkg::OP_GAUGE_SET, 2'h1, 1'h1, 3'h7, 32'h0000_0001, 1'h1, 32'h0);
    // This kilopascal value wraps to a small number, so only the overflow check can refuse it.
    cmdx(plt_pkg::OP_GAUGE_SET, 2'h1, 1'h1, plt_pkg::UNIT_KPA, 32'h0041_8938, 1'h1, 32'h0);
    cmdx(plt_pkg::OP_GAUGE_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0007_a120);
    $display("test units done");
    // With the enable low a measurement is not taken; then a trip and a clear land together.
    ce = 1'h0;
    meas(1, 32'h0000_03e9, 2'h1);
    ce = 1'h1;
    fork
      meas(1, 32'h0000_03e9, 2'h3);
      cmdx(plt_pkg::OP_TRIP_CLR, 2'h2, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0);
    join
    $display("test enable done");
    for (int k = 0; k < 16; k++) begin
      inst_event = k[1:0];
      inst_enable = k[3:2];
      repeat (2) @(posedge core_clk);
      #1;
      cmdx(plt_pkg::OP_COND_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, {18'h0, |(k[1:0] & k[3:2]), 13'h0});
      chk("cond_port", {18'h0, |(k[1:0] & k[3:2]), 13'h0}, {16'h0, operation_condition});
    end
    cmdx(plt_pkg::OP_COND_QRY, 2'h0, 1'h0, 3'h0, 32'h0, 1'h0, 32'h0000_2000);
    $display("test condition done");
    // A second reset stands in for a power cycle: flags and limits return to their start values.
    sys_rst = 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    sys_rst = 1'h0;
    chk("rerun_cond", 32'h0, {16'h0, operation_condition});
    chk("rerun_trip", 32'h0, {30'h0, limit_tripped});
    cmdx(plt_pkg::OP_GAUGE_QRY, 2'h1, 1'h0, 3'h0, 32'h0, 1'h0, 32'hffff_ffff);
    meas(1, 32'h0000_03e9, 2'h0);
    $display("test reset done");
    wrap_up();
  end
endmodule
